// file: hdl/asfc_codec.sv
// Application-service frame parser and builder on a byte stream.
`timescale 1ns/10ps
`include "asfc_cfg.svh"

module asfc_codec
    import asfc_pkg::*;
#(
    parameter int N_ANALOG = 4
) (
    input  wire logic                      core_clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      rx_valid_i,
    input  wire logic [7:0]                rx_data_i,
    input  wire logic                      rx_last_i,
    input  wire asfc_endpoint_t            rx_src_i,
    input  wire logic [31:0]               destination_address_setting_i,
    input  wire logic [15:0]               sample_dst_port_i,
    input  wire logic                      sample_req_i,
    input  wire asfc_sample_t              sample_i,
    input  wire logic [N_ANALOG-1:0][9:0]  analog_i,
    input  wire logic                      tx_ready_i,
    output logic                           ser_valid_o,
    output logic [7:0]                     ser_data_o,
    output logic                           fw_install_o,
    output asfc_install_t                  fw_info_o,
    output logic                           sample_busy_o,
    output logic                           tx_valid_o,
    output logic [7:0]                     tx_data_o,
    output logic                           tx_last_o,
    output asfc_endpoint_t                 tx_dst_o,
    output logic [15:0]                    tx_src_port_o
);

    ////////////////////////////////////////////////////////////////////////
    // Receive side.

    logic [10:0]    rx_idx, next_rx_idx;
    logic [15:0]    word_a, next_word_a;
    logic [15:0]    word_b, next_word_b;
    logic [7:0]     rx_cmd, next_rx_cmd;
    logic [7:0]     rx_opts, next_rx_opts;
    logic [7:0]     mem_sub, next_mem_sub;
    asfc_install_t  mem_info, next_mem_info;
    logic           ack_evt;
    asfc_endpoint_t ack_dst, next_ack_dst;
    logic           next_ser_valid;
    logic [7:0]     next_ser_data;
    logic           next_fw_install;
    asfc_install_t  next_fw_info;
    logic           hdr_ok;

    always_comb begin
        next_rx_idx     = rx_idx;
        next_word_a     = word_a;
        next_word_b     = word_b;
        next_rx_cmd     = rx_cmd;
        next_rx_opts    = rx_opts;
        next_mem_sub    = mem_sub;
        next_mem_info   = mem_info;
        next_ack_dst    = ack_dst;
        next_ser_valid  = 1'b0;
        next_ser_data   = ser_data_o;
        next_fw_install = 1'b0;
        next_fw_info    = fw_info_o;
        ack_evt         = 1'b0;
        hdr_ok          = (word_a ^ word_b) == `ASFC_HDR_MAGIC;
        if (rx_valid_i) begin
            unique case (rx_idx)
                `ASFC_OFS_WORD_A_HI: next_word_a[15:8]      = rx_data_i;
                `ASFC_OFS_WORD_A_LO: next_word_a[7:0]       = rx_data_i;
                `ASFC_OFS_WORD_B_HI: next_word_b[15:8]      = rx_data_i;
                `ASFC_OFS_WORD_B_LO: next_word_b[7:0]       = rx_data_i;
                `ASFC_OFS_CMD:       next_rx_cmd            = rx_data_i;
                `ASFC_OFS_OPTS:      next_rx_opts           = rx_data_i;
                `ASFC_OFS_MEM_SUB:   next_mem_sub           = rx_data_i;
                `ASFC_OFS_MEM_OPTS:  next_mem_info.options  = rx_data_i;
                `ASFC_OFS_BLOCK_HI:  next_mem_info.block[15:8] = rx_data_i;
                `ASFC_OFS_BLOCK_LO:  next_mem_info.block[7:0]  = rx_data_i;
                `ASFC_OFS_START_HI:  next_mem_info.start[15:8] = rx_data_i;
                `ASFC_OFS_START_LO:  next_mem_info.start[7:0]  = rx_data_i;
                `ASFC_OFS_COUNT_HI:  next_mem_info.count[15:8] = rx_data_i;
                `ASFC_OFS_COUNT_LO:  next_mem_info.count[7:0]  = rx_data_i;
                default: ;
            endcase
            // Payload is forwarded only once the header has been checked.
            if (hdr_ok && rx_cmd == `ASFC_CMD_SERIAL
                && rx_idx >= `ASFC_OFS_PAYLOAD
                && rx_idx < `ASFC_OFS_PAYLOAD + `ASFC_MAX_PAYLOAD) begin
                next_ser_valid = 1'b1;
                next_ser_data  = rx_data_i;
            end
            if (rx_idx != 11'h7ff) begin
                next_rx_idx = rx_idx + 11'h001;
            end
            if (rx_last_i) begin
                next_rx_idx = 11'h000;
                // A frame failing the check or shorter than a header is lost.
                if ((next_word_a ^ next_word_b) == `ASFC_HDR_MAGIC
                    && rx_idx >= `ASFC_OFS_OPTS) begin
                    if (next_rx_cmd == `ASFC_CMD_SERIAL
                        && next_rx_opts == `ASFC_OPT_ACK) begin
                        ack_evt      = 1'b1;
                        next_ack_dst = rx_src_i;
                    end
                    if (next_rx_cmd == `ASFC_CMD_MEMORY
                        && next_mem_sub == `ASFC_MEM_INSTALL
                        && rx_idx >= `ASFC_OFS_COUNT_LO) begin
                        next_fw_install = 1'b1;
                        next_fw_info    = next_mem_info;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_idx       <= 11'h000;
            word_a       <= 16'h0000;
            word_b       <= 16'h0000;
            rx_cmd       <= 8'h00;
            rx_opts      <= 8'h00;
            mem_sub      <= 8'h00;
            mem_info     <= '0;
            ack_dst      <= '0;
            ser_valid_o  <= 1'b0;
            ser_data_o   <= 8'h00;
            fw_install_o <= 1'b0;
            fw_info_o    <= '0;
        end else begin
            rx_idx       <= next_rx_idx;
            word_a       <= next_word_a;
            word_b       <= next_word_b;
            rx_cmd       <= next_rx_cmd;
            rx_opts      <= next_rx_opts;
            mem_sub      <= next_mem_sub;
            mem_info     <= next_mem_info;
            ack_dst      <= next_ack_dst;
            ser_valid_o  <= next_ser_valid;
            ser_data_o   <= next_ser_data;
            fw_install_o <= next_fw_install;
            fw_info_o    <= next_fw_info;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit side.

    function automatic logic [7:0] fixed_byte(input logic [3:0] idx,
                                              input logic is_smp,
                                              input asfc_sample_t s);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            4'h0:    b = 8'(`ASFC_HDR_MAGIC >> 8);
            4'h1:    b = 8'(`ASFC_HDR_MAGIC & 16'h00ff);
            4'h6:    b = is_smp ? `ASFC_CMD_SAMPLE : `ASFC_CMD_ACK;
            4'h7:    b = `ASFC_OPT_NONE;
            4'h8:    b = `ASFC_SAMPLE_SETS;
            4'h9:    b = s.digital_mask[15:8];
            4'ha:    b = s.digital_mask[7:0];
            4'hb:    b = s.analog_mask;
            4'hc:    b = s.digital_word[15:8];
            4'hd:    b = s.digital_word[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : fixed_byte

    function automatic logic any_from(input logic [7:0] mask,
                                      input int first);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i >= first && i < N_ANALOG && mask[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : any_from

    asfc_tx_state_t           tx_state, next_tx_state;
    logic [3:0]               tx_idx, next_tx_idx;
    logic                     tx_smp, next_tx_smp;
    logic [2:0]               ana_ch, next_ana_ch;
    logic                     ana_lo, next_ana_lo;
    logic                     ack_pend, next_ack_pend;
    logic                     smp_pend, next_smp_pend;
    asfc_sample_t             smp, next_smp;
    logic [N_ANALOG-1:0][9:0] ana, next_ana;
    logic                     next_tx_valid;
    logic [7:0]               next_tx_data;
    logic                     next_tx_last;
    asfc_endpoint_t           next_tx_dst;
    logic                     tx_load;
    logic [15:0]              ana_word;
    logic                     fixed_end;
    logic                     next_sample_busy;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_idx   = tx_idx;
        next_tx_smp   = tx_smp;
        next_ana_ch   = ana_ch;
        next_ana_lo   = ana_lo;
        next_ack_pend = ack_pend;
        next_smp_pend = smp_pend;
        next_smp      = smp;
        next_ana      = ana;
        next_tx_valid = tx_valid_o;
        next_tx_data  = tx_data_o;
        next_tx_last  = tx_last_o;
        next_tx_dst   = tx_dst_o;
        tx_load       = !tx_valid_o || tx_ready_i;
        ana_word      = {6'h00, ana[ana_ch]};
        fixed_end     = 1'b0;
        if (tx_load) begin
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
        end
        unique case (tx_state)
            TX_IDLE: begin
                if (ack_pend) begin
                    next_ack_pend = 1'b0;
                    next_tx_smp   = 1'b0;
                    next_tx_dst   = ack_dst;
                    next_tx_idx   = 4'h0;
                    next_tx_state = TX_FIXED;
                end else if (smp_pend) begin
                    next_smp_pend = 1'b0;
                    next_tx_smp   = 1'b1;
                    next_tx_dst   = {destination_address_setting_i,
                                     sample_dst_port_i};
                    next_tx_idx   = 4'h0;
                    next_tx_state = TX_FIXED;
                end
            end
            TX_FIXED: begin
                if (tx_load) begin
                    next_tx_valid = 1'b1;
                    next_tx_data  = fixed_byte(tx_idx, tx_smp, smp);
                    next_tx_idx   = tx_idx + 4'h1;
                    if (!tx_smp) begin
                        fixed_end = tx_idx == `ASFC_TX_HDR_LAST;
                    end else if (smp.digital_mask == 16'h0000) begin
                        fixed_end = tx_idx == `ASFC_TX_AMASK_IDX;
                    end else begin
                        fixed_end = tx_idx == `ASFC_TX_DWORD_LAST;
                    end
                    if (fixed_end) begin
                        next_ana_ch = 3'h0;
                        next_ana_lo = 1'b0;
                        if (tx_smp && any_from(smp.analog_mask, 0)) begin
                            next_tx_state = TX_ANALOG;
                        end else begin
                            next_tx_last  = 1'b1;
                            next_tx_state = TX_IDLE;
                        end
                    end
                end
            end
            TX_ANALOG: begin
                if (tx_load) begin
                    if (!smp.analog_mask[ana_ch]) begin
                        next_ana_ch = ana_ch + 3'h1;
                    end else if (!ana_lo) begin
                        next_tx_valid = 1'b1;
                        next_tx_data  = ana_word[15:8];
                        next_ana_lo   = 1'b1;
                    end else begin
                        next_tx_valid = 1'b1;
                        next_tx_data  = ana_word[7:0];
                        next_ana_lo   = 1'b0;
                        next_ana_ch   = ana_ch + 3'h1;
                        if (!any_from(smp.analog_mask, int'(ana_ch) + 1)) begin
                            next_tx_last  = 1'b1;
                            next_tx_state = TX_IDLE;
                        end
                    end
                end
            end
        endcase
        // An ack event is set after the clears so that one arriving as ack_pend clears is kept.
        if (ack_evt) begin
            next_ack_pend = 1'b1;
        end
        if (sample_req_i && !smp_pend
            && !(tx_state != TX_IDLE && tx_smp)) begin
            next_smp_pend = 1'b1;
            next_smp      = sample_i;
            next_ana      = analog_i;
        end
        next_sample_busy = next_smp_pend
                           || (next_tx_state != TX_IDLE && next_tx_smp);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_state      <= TX_IDLE;
            tx_idx        <= 4'h0;
            tx_smp        <= 1'b0;
            ana_ch        <= 3'h0;
            ana_lo        <= 1'b0;
            ack_pend      <= 1'b0;
            smp_pend      <= 1'b0;
            smp           <= '0;
            ana           <= '0;
            tx_valid_o    <= 1'b0;
            tx_data_o     <= 8'h00;
            tx_last_o     <= 1'b0;
            tx_dst_o      <= '0;
            tx_src_port_o <= `ASFC_SERVICE_PORT;
            sample_busy_o <= 1'b0;
        end else begin
            tx_state      <= next_tx_state;
            tx_idx        <= next_tx_idx;
            tx_smp        <= next_tx_smp;
            ana_ch        <= next_ana_ch;
            ana_lo        <= next_ana_lo;
            ack_pend      <= next_ack_pend;
            smp_pend      <= next_smp_pend;
            smp           <= next_smp;
            ana           <= next_ana;
            tx_valid_o    <= next_tx_valid;
            tx_data_o     <= next_tx_data;
            tx_last_o     <= next_tx_last;
            tx_dst_o      <= next_tx_dst;
            tx_src_port_o <= `ASFC_SERVICE_PORT;
            sample_busy_o <= next_sample_busy;
        end
    end

endmodule : asfc_codec

// file: inc/asfc_cfg.svh
// Constants for the application-service frame codec.
`ifndef ASFC_CFG_SVH
`define ASFC_CFG_SVH

`define ASFC_HDR_MAGIC      16'h4242
`define ASFC_OFS_WORD_A_HI  11'h000
`define ASFC_OFS_WORD_A_LO  11'h001
`define ASFC_OFS_WORD_B_HI  11'h002
`define ASFC_OFS_WORD_B_LO  11'h003
`define ASFC_OFS_PACKET_ID  11'h004
`define ASFC_OFS_PAD        11'h005
`define ASFC_OFS_CMD        11'h006
`define ASFC_OFS_OPTS       11'h007
`define ASFC_OFS_PAYLOAD    11'h008
`define ASFC_OFS_MEM_SUB    11'h008
`define ASFC_OFS_MEM_OPTS   11'h009
`define ASFC_OFS_BLOCK_HI   11'h00a
`define ASFC_OFS_BLOCK_LO   11'h00b
`define ASFC_OFS_START_HI   11'h00c
`define ASFC_OFS_START_LO   11'h00d
`define ASFC_OFS_COUNT_HI   11'h00e
`define ASFC_OFS_COUNT_LO   11'h00f
`define ASFC_MAX_PAYLOAD    11'h5d4
`define ASFC_CMD_SERIAL     8'h00
`define ASFC_CMD_MEMORY     8'h03
`define ASFC_CMD_SAMPLE     8'h04
`define ASFC_CMD_ACK        8'h80
`define ASFC_OPT_NONE       8'h00
`define ASFC_OPT_ACK        8'h02
`define ASFC_MEM_INSTALL    8'h06
`define ASFC_SAMPLE_SETS    8'h01
`define ASFC_SERVICE_PORT   16'h0bee
`define ASFC_TX_HDR_LAST    4'h7
`define ASFC_TX_AMASK_IDX   4'hb
`define ASFC_TX_DWORD_LAST  4'hd

`endif

// file: inc/asfc_pkg.sv
// Types shared by the application-service frame codec.
package asfc_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] port;
    } asfc_endpoint_t;

    typedef struct packed {
        logic [15:0] digital_mask;
        logic [7:0]  analog_mask;
        logic [15:0] digital_word;
    } asfc_sample_t;

    typedef struct packed {
        logic [7:0]  options;
        logic [15:0] block;
        logic [15:0] start;
        logic [15:0] count;
    } asfc_install_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_FIXED,
        TX_ANALOG
    } asfc_tx_state_t;

endpackage : asfc_pkg

// file: tb/asfc_client_sink.sv
// Network client model that takes outgoing frames, promptly or with stalls.
`timescale 1ns/10ps

module asfc_client_sink (
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       slow_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    output logic            tx_ready_o
);
    logic [7:0] q[$];
    int         lens[$];
    int         cur;

    // Every byte is kept, duplicates of resent frames included.
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_ready_o <= 1'b0;
            cur = 0;
        end else begin
            if (tx_valid_i && tx_ready_o) begin
                q.push_back(tx_data_i);
                cur++;
                if (tx_last_i) begin
                    lens.push_back(cur);
                    cur = 0;
                end
            end
            tx_ready_o <= slow_i ? 1'($urandom) : 1'b1;
        end
    end
endmodule : asfc_client_sink

// file: tb/asfc_codec_properties.sv
// Concurrent checks on the ports of the application-service frame codec.
`timescale 1ns/10ps

module asfc_codec_properties (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_last_i,
    input  wire logic        sample_req_i,
    input  wire logic        tx_ready_i,
    input  wire logic        ser_valid_o,
    input  wire logic        fw_install_o,
    input  wire logic        sample_busy_o,
    input  wire logic        tx_valid_o,
    input  wire logic [7:0]  tx_data_o,
    input  wire logic        tx_last_o,
    input  wire logic [15:0] tx_src_port_o
);
    logic [10:0] cnt;
    logic [7:0]  cmd;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////
    // Position of the byte on offer within the outgoing frame.
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt <= 11'h000;
            cmd <= 8'h00;
        end else if (tx_valid_o && tx_ready_i) begin
            cnt <= tx_last_o ? 11'h000 : cnt + 11'h001;
            if (cnt == 11'h006) begin
                cmd <= tx_data_o;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_frame_magic: assert property (tx_valid_o && cnt < 11'h002 |->
        tx_data_o == 8'h42) else $error("outgoing header word wrong");
    a_hdr_zero: assert property (tx_valid_o && cnt >= 11'h002 &&
        cnt <= 11'h005 |-> tx_data_o == 8'h00)
        else $error("outgoing header bytes 2 to 5 not zero");
    a_cmd_code: assert property (tx_valid_o && cnt == 11'h006 |->
        tx_data_o inside {8'h80, 8'h04}) else $error("bad outgoing command");
    a_opts_zero: assert property (tx_valid_o && cnt == 11'h007 |->
        tx_data_o == 8'h00) else $error("outgoing options not zero");
    a_ack_short: assert property (tx_valid_o && tx_last_o &&
        cmd == 8'h80 |-> cnt == 11'h007) else $error("ack frame too long");
    a_sample_len: assert property (tx_valid_o && tx_last_o &&
        cmd == 8'h04 |-> cnt >= 11'h00b) else $error("sample frame short");
    a_set_count: assert property (tx_valid_o && cnt == 11'h008 |->
        tx_data_o == 8'h01 && cmd == 8'h04) else $error("bad set count");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
        else $error("tx byte changed before it was taken");
    a_src_port: assert property (tx_src_port_o == 16'h0bee)
        else $error("source port not the service port");
    a_ser_cause: assert property (ser_valid_o |-> $past(rx_valid_i))
        else $error("serial byte without a received byte");
    a_fw_cause: assert property (fw_install_o |->
        $past(rx_valid_i && rx_last_i)) else $error("install not at last");
    a_busy_set: assert property (sample_req_i && !sample_busy_o |=>
        sample_busy_o) else $error("sample request not taken");

    c_install: cover property (fw_install_o);
    c_ack: cover property (tx_valid_o && tx_last_o && cnt == 11'h007);
    c_stall: cover property (tx_valid_o && !tx_ready_i);
    c_serial: cover property (ser_valid_o);
endmodule : asfc_codec_properties

bind asfc_codec asfc_codec_properties u_props (.core_clk_i, .resetn_i,
    .rx_valid_i, .rx_last_i, .sample_req_i, .tx_ready_i, .ser_valid_o,
    .fw_install_o, .sample_busy_o, .tx_valid_o, .tx_data_o, .tx_last_o,
    .tx_src_port_o);

// file: tb/test_asfc_codec.sv
// Randomised self-checking bench for the application-service frame codec.
`timescale 1ns/10ps
`include "asfc_cfg.svh"

module test_asfc_codec
    import asfc_pkg::*;
;
    typedef logic [7:0] asfc_bq_t[$];
    localparam int NA = 4;
    logic core_clk_i, resetn_i, rx_valid_i, rx_last_i, sample_req_i;
    logic tx_ready_i, slow, ser_valid_o, fw_install_o, sample_busy_o;
    logic tx_valid_o, tx_last_o;
    logic [7:0]            rx_data_i, ser_data_o, tx_data_o;
    logic [31:0]           destination_address_setting_i;
    logic [15:0]           sample_dst_port_i, tx_src_port_o;
    asfc_endpoint_t        rx_src_i, tx_dst_o;
    asfc_sample_t          sample_i;
    logic [NA-1:0][9:0]    analog_i;
    asfc_install_t         fw_info_o;
    int                    err_count, checks_done, fw_n;
    asfc_bq_t              ser_q;

    asfc_codec #(.N_ANALOG(NA)) DUT (.core_clk_i, .resetn_i, .rx_valid_i,
        .rx_data_i, .rx_last_i, .rx_src_i, .destination_address_setting_i,
        .sample_dst_port_i, .sample_req_i, .sample_i, .analog_i, .tx_ready_i,
        .ser_valid_o, .ser_data_o, .fw_install_o, .fw_info_o, .sample_busy_o,
        .tx_valid_o, .tx_data_o, .tx_last_o, .tx_dst_o, .tx_src_port_o);
    asfc_client_sink sink (.core_clk_i, .resetn_i, .slow_i(slow),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (ser_valid_o === 1'b1) ser_q.push_back(ser_data_o);
        if (fw_install_o === 1'b1) fw_n++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk_val(string n, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val

    function automatic asfc_bq_t hdr(logic [15:0] wa, logic [15:0] bad,
                                     logic [7:0] cmd, logic [7:0] opt);
        logic [15:0] wb;
        wb = wa ^ `ASFC_HDR_MAGIC ^ bad;
        return '{wa[15:8], wa[7:0], wb[15:8], wb[7:0], 8'h00, 8'h00, cmd, opt};
    endfunction : hdr

    function automatic asfc_bq_t exp_smp(asfc_sample_t s,
                                         logic [NA-1:0][9:0] a);
        asfc_bq_t q;
        q = hdr(16'h4242, 16'h0000, `ASFC_CMD_SAMPLE, 8'h00);
        q = {q, 8'h01, s.digital_mask[15:8], s.digital_mask[7:0],
             s.analog_mask};
        if (s.digital_mask != 16'h0000)
            q = {q, s.digital_word[15:8], s.digital_word[7:0]};
        for (int i = 0; i < NA; i++)
            if (s.analog_mask[i]) q = {q, 8'({6'h00, a[i][9:8]}), a[i][7:0]};
        return q;
    endfunction : exp_smp

    task automatic send(asfc_bq_t f);
        foreach (f[i]) begin
            @(posedge core_clk_i);
            rx_valid_i <= 1'b1;
            rx_data_i  <= f[i];
            rx_last_i  <= (i == f.size() - 1);
        end
        @(posedge core_clk_i);
        rx_valid_i <= 1'b0;
        rx_last_i  <= 1'b0;
    endtask : send

    task automatic chk_frame(string n, asfc_bq_t e, asfc_endpoint_t d);
        int k;
        int len;
        k = 0;
        while (sink.lens.size() == 0 && k < 4000) begin
            @(posedge core_clk_i);
            k++;
        end
        len = (sink.lens.size() != 0) ? sink.lens.pop_front() : 0;
        chk_val({n, " length"}, 64'(e.size()), 64'(len));
        for (int i = 0; i < len; i++)
            if (i < e.size()) chk_val(n, e[i], sink.q.pop_front());
            else void'(sink.q.pop_front());
        chk_val({n, " destination"}, 64'(d), 64'(tx_dst_o));
    endtask : chk_frame

    task automatic chk_none();
        repeat (40) @(posedge core_clk_i);
        chk_val("unexpected frames", 64'h0, 64'(sink.lens.size()));
    endtask : chk_none

    task automatic serial(logic [7:0] opt, int n, logic [15:0] bad, int reps);
        asfc_bq_t f, p;
        asfc_endpoint_t src;
        f = hdr(16'($urandom), bad, `ASFC_CMD_SERIAL, opt);
        for (int i = 0; i < n; i++) p.push_back(8'($urandom));
        src = {$urandom, 16'($urandom)};
        rx_src_i <= src;
        f = {f, p};
        while (p.size() > 1492) p.pop_back();
        if (bad != 16'h0000) p.delete();
        for (int r = 0; r < reps; r++) begin
            send(f);
            repeat (4) @(posedge core_clk_i);
            chk_val("serial count", 64'(p.size()), 64'(ser_q.size()));
            foreach (p[i]) chk_val("serial byte", p[i], ser_q[i]);
            ser_q.delete();
            if (opt == `ASFC_OPT_ACK && bad == 16'h0000)
                chk_frame("ack", hdr(16'h4242, 0, 8'h80, 0), src);
            else chk_none();
        end
    endtask : serial

    task automatic mem(logic [7:0] sub, int ok);
        asfc_install_t i;
        int n0;
        i = 56'({$urandom, $urandom});
        n0 = fw_n;
        send({hdr(16'($urandom), 0, `ASFC_CMD_MEMORY, 0), sub, i.options,
              i.block[15:8], i.block[7:0], i.start[15:8], i.start[7:0],
              i.count[15:8], i.count[7:0]});
        repeat (3) @(posedge core_clk_i);
        chk_val("install pulses", 64'(ok), 64'(fw_n - n0));
        if (ok != 0) chk_val("install info", 64'(i), 64'(fw_info_o));
    endtask : mem

    task automatic do_smp(asfc_sample_t s, logic [NA-1:0][9:0] a);
        @(posedge core_clk_i);
        sample_req_i <= 1'b1;
        sample_i     <= s;
        analog_i     <= a;
        @(posedge core_clk_i);
        sample_req_i <= 1'b0;
        @(posedge core_clk_i);
        sample_req_i <= 1'b1;
        sample_i     <= ~s;
        @(posedge core_clk_i);
        sample_req_i <= 1'b0;
        chk_val("sample busy", 64'h1, 64'(sample_busy_o));
        chk_frame("sample", exp_smp(s, a),
                  {destination_address_setting_i, sample_dst_port_i});
        chk_none();
        chk_val("sample idle", 64'h0, 64'(sample_busy_o));
        chk_val("source port", `ASFC_SERVICE_PORT, tx_src_port_o);
    endtask : do_smp

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        err_count++;
        close_out();
    end

    initial begin
        asfc_bq_t cut;
        {resetn_i, rx_valid_i, rx_last_i, sample_req_i, slow} = '0;
        {rx_data_i, rx_src_i, sample_i, analog_i} = '0;
        destination_address_setting_i = 32'h0a00_0105;
        sample_dst_port_i = 16'h2616;
        void'($urandom(57));
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(posedge core_clk_i);
        serial(`ASFC_OPT_ACK, 5, 16'h0000, 2);
        cut = hdr(16'h1234, 16'h0000, `ASFC_CMD_SERIAL, `ASFC_OPT_ACK);
        cut.pop_back();
        send(cut);
        chk_none();
        serial(`ASFC_OPT_NONE, 3, 16'h0000, 1);
        serial(8'h01, 2, 16'h0000, 1);
        serial(`ASFC_OPT_ACK, 4, 16'h0100, 1);
        serial(`ASFC_OPT_NONE, 1494, 16'h0000, 1);
        mem(`ASFC_MEM_INSTALL, 1);
        mem(8'h05, 0);
        slow <= 1'b1;
        do_smp({16'h0000, 8'hf2, 16'h1234},
               {10'h3ff, 10'h155, 10'h200, 10'h001});
        do_smp({16'h0101, 8'h02, 16'h0001}, {4{10'h200}});
        for (int k = 0; k < 8; k++) begin
            do_smp(40'({$urandom, $urandom}), 40'({$urandom, $urandom}));
            serial(8'(k % 3), 1 + $urandom % 12, 16'h0000, 1);
        end
        close_out();
    end
endmodule : test_asfc_codec
